//--- hook_timer.sv
/*
 * Loadable down counter that pulses done when a loaded count expires.
 * Assumes load values of at least one; a new load restarts the count.
 */
`timescale 1ns/10ps
module hook_timer #(
	parameter int CNT_W = 26
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [CNT_W-1:0] load_val,
	output logic busy,
	output logic done
);
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic done_q;
	logic done_d;

	always_comb begin
		cnt_d = cnt_q;
		done_d = 1'b0;
		if (load) begin
			cnt_d = load_val;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
			done_d = (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= '0;
			done_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			done_q <= done_d;
		end
	end

	assign busy = (cnt_q != '0);
	assign done = done_q;
endmodule : hook_timer

//--- line_side_model.sv
/* Line-side model: signed loop voltage in volts.
 * Assumes the bench sets volts and line presence. */
`timescale 1ns/10ps
module line_side_model (
	input wire logic connected,
	input wire logic [7:0] volts,
	output logic [7:0] line_volt_raw
);
	// No line connected reads 0 V
	assign line_volt_raw = connected ? volts : 8'h00;
endmodule : line_side_model

//--- line_term_params.svh
/*
 * Offsets, field positions, reset values and timing figures of the line termination
 * control register bank.
 * Assumes inclusion by bare name from any file that needs them.
 */
`ifndef LINE_TERM_PARAMS_SVH
`define LINE_TERM_PARAMS_SVH

`define AC_TERM_IDX 6'h1E
`define LINE_CTL5_IDX 6'h1F
`define LINE_VOLT_IDX 6'h1D

`define AC_TERM_RESET 8'h00
`define LINE_CTL5_RESET 8'h20
`define AC_TERM_RW_MASK 8'h3F
`define LINE_CTL5_RW_MASK 8'hEB

`define AC_IMPEDANCE_SELECT_LSB 0
`define AC_IMPEDANCE_SELECT_MSB 3
`define BOOST_BIT 4
`define SPARE_BIT 5
`define CLAMP_OFF_BIT 0
`define HIGHPASS_BIT 1
`define ONHOOK_EXT_BIT 3
`define FOH_LSB 5
`define FOH_MSB 6
`define STD_FS_BIT 7

`define AC_IMPEDANCE_SELECT_600 4'h0
`define AC_IMPEDANCE_SELECT_900 4'h1
`define AC_IMPEDANCE_SELECT_GLOBAL 4'hF

`define CLK_MHZ 100
`define FOH_512_US 512000
`define FOH_128_US 128000
`define FOH_64_US 64000
`define FOH_8_US 8000
`define ONHOOK_FAST_US 500
`define ONHOOK_ETSI_US 3000
`define ONHOOK_QUENCH_US 26000

`define CLAMP_VOLTS 8'h03
`define DCT_MV_00 12'hC1C
`define DCT_MV_01 12'hC80
`define DCT_MV_10 12'hD16
`define DCT_MV_11 12'hDAC

`endif

//--- line_term_pkg.sv
/*
 * Types of the line termination control register bank.
 * Assumes nothing of its surroundings.
 */
package line_term_pkg;

	typedef enum logic [1:0] {FS_DEFAULT, FS_STD_3P2, FS_BOOST_6} fs_mode_t;
	typedef enum logic {HP_5HZ, HP_200HZ} hp_corner_t;
	typedef enum logic [1:0] {HS_ONHOOK, HS_QUAL, HS_OFFHOOK, HS_RELEASE} hook_state_t;

endpackage : line_term_pkg

//--- line_term_regs.sv
/*
 * Line termination control register bank on an Avalon-MM slave with waitrequest,
 * with the off-hook qualify and on-hook release timing it steers.
 * Assumes a byte-addressed master, one clock, and hook and line inputs that are
 * already synchronous to clk.
 */
`timescale 1ns/10ps
`include "line_term_params.svh"

// How it works
// - Boost bit set selects the plus six dBm full scale; clear leaves the standard bit to decide.
// - Four-bit impedance code picks termination: 0 600, 1 900, F global.
// - Standard full scale bit selects plus 3.2 dBm; clear keeps default.
// - Off-hook counter length codes give 512, 128, 64, 8 ms; 128 after reset.
// - On-hook release time is 0.5, 3 or 26 ms by speed bits.
// - Receive high-pass corner is 5 Hz when clear, 200 Hz when set.
// - Clamp on forces readings of magnitude 3 V or less to zero; off passes.
// - Tip/ring adjust code sets reference voltage; code 11 gives 3.5 V.
// - Line reading is signed 8-bit, 1 V per step, top bit polarity.
module line_term_regs
	import line_term_pkg::*;
#(
	parameter int CNT_W = 26,
	// Divides every hook count at once; 1 gives real time
	parameter int TIME_DIV = 1,
	parameter logic [CNT_W-1:0] FOH_512_CYC =
		CNT_W'(`FOH_512_US * `CLK_MHZ / TIME_DIV),
	parameter logic [CNT_W-1:0] FOH_128_CYC =
		CNT_W'(`FOH_128_US * `CLK_MHZ / TIME_DIV),
	parameter logic [CNT_W-1:0] FOH_64_CYC =
		CNT_W'(`FOH_64_US * `CLK_MHZ / TIME_DIV),
	parameter logic [CNT_W-1:0] FOH_8_CYC =
		CNT_W'(`FOH_8_US * `CLK_MHZ / TIME_DIV),
	parameter logic [CNT_W-1:0] ONHOOK_FAST_CYC =
		CNT_W'(`ONHOOK_FAST_US * `CLK_MHZ / TIME_DIV),
	parameter logic [CNT_W-1:0] ONHOOK_ETSI_CYC =
		CNT_W'(`ONHOOK_ETSI_US * `CLK_MHZ / TIME_DIV),
	parameter logic [CNT_W-1:0] ONHOOK_QUENCH_CYC =
		CNT_W'(`ONHOOK_QUENCH_US * `CLK_MHZ / TIME_DIV)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic offhook_request,
	input wire logic onhook_speed_base,
	input wire logic [1:0] spark_quench_sel,
	input wire logic [1:0] tip_ring_volt_adj,
	input wire logic [7:0] line_volt_raw,
	output logic [3:0] ac_impedance_select,
	output logic termination_global,
	output fs_mode_t fullscale_mode,
	output hp_corner_t rx_highpass_sel,
	output logic [11:0] dct_ref_mv,
	output logic [7:0] line_volt_reading,
	output logic tip_ring_polarity,
	output logic offhook_valid,
	output logic loop_current_on
);
	logic [7:0] ac_term_q;
	logic [7:0] ac_term_d;
	logic [7:0] ctl5_q;
	logic [7:0] ctl5_d;
	logic ack_q;
	logic ack_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [5:0] idx;
	logic hit_term;
	logic hit_ctl5;
	logic hit_volt;
	logic wr_now;

	// Single-cycle wait keeps read data registered before the answer edge
	assign waitrequest = (read | write) & ~ack_q;
	assign idx = address[7:2];
	assign hit_term = (address[1:0] == 2'h0) && (idx == `AC_TERM_IDX);
	assign hit_ctl5 = (address[1:0] == 2'h0) && (idx == `LINE_CTL5_IDX);
	assign hit_volt = (address[1:0] == 2'h0) && (idx == `LINE_VOLT_IDX);
	assign wr_now = write & ack_q;

	always_comb begin
		ack_d = (read | write) & ~ack_q;
		ac_term_d = ac_term_q;
		ctl5_d = ctl5_q;
		rdata_d = rdata_q;
		if (wr_now && hit_term) begin
			ac_term_d = writedata[7:0] & `AC_TERM_RW_MASK;
		end
		if (wr_now && hit_ctl5) begin
			ctl5_d = writedata[7:0] & `LINE_CTL5_RW_MASK;
		end
		if (read && !ack_q) begin
			rdata_d = 32'h0000_0000; // Unmapped reads answer zero
			if (hit_term) begin
				rdata_d = {24'h00_0000, ac_term_q};
			end else if (hit_ctl5) begin
				rdata_d = {24'h00_0000, ctl5_q};
			end else if (hit_volt) begin
				rdata_d = {24'h00_0000, line_volt_reading};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			ac_term_q <= `AC_TERM_RESET;
			ctl5_q <= `LINE_CTL5_RESET;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= ack_d;
			ac_term_q <= ac_term_d;
			ctl5_q <= ctl5_d;
			rdata_q <= rdata_d;
		end
	end

	assign readdata = rdata_q;

	// Field decode toward the analog front end
	assign ac_impedance_select = ac_term_q[`AC_IMPEDANCE_SELECT_MSB:`AC_IMPEDANCE_SELECT_LSB];
	assign termination_global = (ac_impedance_select == `AC_IMPEDANCE_SELECT_GLOBAL);
	// Boost wins if software sets both scale bits
	assign fullscale_mode = ac_term_q[`BOOST_BIT] ? FS_BOOST_6 :
		(ctl5_q[`STD_FS_BIT] ? FS_STD_3P2 : FS_DEFAULT);
	assign rx_highpass_sel = ctl5_q[`HIGHPASS_BIT] ? HP_200HZ : HP_5HZ;

	always_comb begin
		case (tip_ring_volt_adj)
			2'b00: dct_ref_mv = `DCT_MV_00;
			2'b01: dct_ref_mv = `DCT_MV_01;
			2'b10: dct_ref_mv = `DCT_MV_10;
			default: dct_ref_mv = `DCT_MV_11;
		endcase
	end

	// Line voltage reading with low-voltage clamp
	logic [7:0] lv_q;
	logic [7:0] lv_d;
	logic [7:0] lv_mag;

	always_comb begin
		lv_mag = line_volt_raw[7] ? (8'h00 - line_volt_raw) : line_volt_raw;
		lv_d = line_volt_raw;
		if (!ctl5_q[`CLAMP_OFF_BIT] && (lv_mag <= `CLAMP_VOLTS)) begin
			lv_d = 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lv_q <= 8'h00;
		end else begin
			lv_q <= lv_d;
		end
	end

	assign line_volt_reading = lv_q;
	assign tip_ring_polarity = lv_q[7];

	// Hook sequencing
	hook_state_t hs_q;
	hook_state_t hs_d;
	logic req_prev_q;
	logic req_prev_d;
	logic tmr_load;
	logic [CNT_W-1:0] tmr_val;
	logic [CNT_W-1:0] foh_cyc;
	logic [CNT_W-1:0] onhook_cyc;
	logic tmr_busy;
	logic tmr_done;

	always_comb begin
		case (ctl5_q[`FOH_MSB:`FOH_LSB])
			2'b00: foh_cyc = FOH_512_CYC;
			2'b01: foh_cyc = FOH_128_CYC;
			2'b10: foh_cyc = FOH_64_CYC;
			default: foh_cyc = FOH_8_CYC;
		endcase
	end

	// Unlisted speed combinations fall back to the fastest release
	always_comb begin
		onhook_cyc = ONHOOK_FAST_CYC;
		if (onhook_speed_base && (spark_quench_sel == 2'b11)) begin
			onhook_cyc = ONHOOK_QUENCH_CYC;
		end else if (!onhook_speed_base && ctl5_q[`ONHOOK_EXT_BIT]
			&& (spark_quench_sel == 2'b00)) begin
			onhook_cyc = ONHOOK_ETSI_CYC;
		end
	end

	always_comb begin
		hs_d = hs_q;
		req_prev_d = offhook_request;
		tmr_load = 1'b0;
		tmr_val = foh_cyc;
		case (hs_q)
			HS_ONHOOK: begin
				if (offhook_request && !req_prev_q) begin
					hs_d = HS_QUAL;
					tmr_load = 1'b1;
				end
			end
			HS_QUAL: begin
				if (!offhook_request) begin
					hs_d = HS_RELEASE;
					tmr_load = 1'b1;
					tmr_val = onhook_cyc;
				end else if (tmr_done) begin
					hs_d = HS_OFFHOOK;
				end
			end
			HS_OFFHOOK: begin
				if (!offhook_request) begin
					hs_d = HS_RELEASE;
					tmr_load = 1'b1;
					tmr_val = onhook_cyc;
				end
			end
			HS_RELEASE: begin
				// A new request waits until loop current has ceased
				if (tmr_done) begin
					hs_d = HS_ONHOOK;
					req_prev_d = 1'b0;
				end
			end
			default: begin
				hs_d = HS_ONHOOK;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hs_q <= HS_ONHOOK;
			req_prev_q <= 1'b0;
		end else begin
			hs_q <= hs_d;
			req_prev_q <= req_prev_d;
		end
	end

	hook_timer #(
		.CNT_W(CNT_W)
	) u_hook_timer (
		.clk(clk),
		.rst_n(rst_n),
		.load(tmr_load),
		.load_val(tmr_val),
		.busy(tmr_busy),
		.done(tmr_done)
	);

	assign offhook_valid = (hs_q == HS_OFFHOOK);
	assign loop_current_on = (hs_q != HS_ONHOOK);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence seq_wr_term;
		wr_now && hit_term;
	endsequence

	sequence seq_wr_ctl5;
		wr_now && hit_ctl5;
	endsequence

	sequence seq_rd_ctl5;
		read && !ack_q && hit_ctl5 ##1 ack_q;
	endsequence

	AST_BOOST_SCALE: assert property (
		seq_wr_term ##0 writedata[`BOOST_BIT] |=> (fullscale_mode == FS_BOOST_6) [*2])
		else $error("boost scale not selected after write");
	AST_STD_SCALE: assert property (
		seq_wr_ctl5 ##0 (writedata[`STD_FS_BIT] && !ac_term_q[`BOOST_BIT])
		|=> fullscale_mode == FS_STD_3P2)
		else $error("standard scale not selected after write");
	AST_IMPEDANCE: assert property (
		seq_wr_term |=> ac_impedance_select == $past(writedata[3:0])
		&& termination_global == ($past(writedata[3:0]) == `AC_IMPEDANCE_SELECT_GLOBAL))
		else $error("impedance select does not follow write");
	AST_FOH_LOAD: assert property (
		hs_q == HS_ONHOOK && hs_d == HS_QUAL |-> tmr_load
		&& tmr_val == (ctl5_q[6:5] == 2'b00 ? FOH_512_CYC : ctl5_q[6:5] == 2'b01 ? FOH_128_CYC
		: ctl5_q[6:5] == 2'b10 ? FOH_64_CYC : FOH_8_CYC))
		else $error("off-hook counter loaded with wrong length");
	AST_ONHOOK_ETSI: assert property (
		hs_q == HS_OFFHOOK && !offhook_request && !onhook_speed_base
		&& ctl5_q[`ONHOOK_EXT_BIT] && spark_quench_sel == 2'b00
		|-> tmr_load && tmr_val == ONHOOK_ETSI_CYC ##1 hs_q == HS_RELEASE)
		else $error("on-hook release not timed at 3 ms");
	AST_RELEASE_END: assert property (
		hs_q == HS_RELEASE && tmr_done |=> !loop_current_on)
		else $error("loop current not ended after release time");
	AST_HIGHPASS: assert property (
		seq_wr_ctl5 |=> rx_highpass_sel == ($past(writedata[1]) ? HP_200HZ : HP_5HZ))
		else $error("receive corner does not follow write");
	AST_CLAMP: assert property (
		!ctl5_q[`CLAMP_OFF_BIT] && !$changed(ctl5_q) && line_volt_raw == 8'hFD
		|=> line_volt_reading == 8'h00)
		else $error("low line voltage not forced to zero");
	AST_PASS_SIGNED: assert property (
		ctl5_q[`CLAMP_OFF_BIT] && !$changed(ctl5_q)
		|=> line_volt_reading == $past(line_volt_raw)
		&& tip_ring_polarity == $past(line_volt_raw[7]))
		else $error("line reading not passed through");
	AST_DCT_TOP: assert property (
		tip_ring_volt_adj == 2'b11 |-> dct_ref_mv == 12'hDAC)
		else $error("top adjust code not 3.5 V");
	AST_READBACK: assert property (
		seq_rd_ctl5 |-> !waitrequest && readdata[31:8] == 24'h00_0000
		&& readdata[4] == 1'b0 && readdata[2] == 1'b0 && readdata[7:0] == ctl5_q)
		else $error("control read back wrong");
endmodule : line_term_regs

//--- testbench.sv
/* Self-checking bench of the line termination register bank.
 * Assumes short hook counts and one 100 MHz clock. */
`timescale 1ns/10ps
module testbench;
	import line_term_pkg::*;
	logic clk, rst_n, read, write, offhook_request, onhook_speed_base, connected;
	logic waitrequest, termination_global, tip_ring_polarity, offhook_valid, loop_current_on;
	logic [7:0] address, volts, line_volt_raw, line_volt_reading;
	logic [31:0] writedata, readdata, rd;
	logic [1:0] spark_quench_sel, tip_ring_volt_adj;
	logic [3:0] ac_impedance_select;
	logic [11:0] dct_ref_mv;
	fs_mode_t fullscale_mode;
	hp_corner_t rx_highpass_sel;
	int err_count, compares, cyc, n;

	// Divider shrinks every hook count to keep the run brief
	line_term_regs #(.TIME_DIV(50000)) line_term_regs_i (.clk, .rst_n, .address, .read,
		.write, .writedata, .readdata, .waitrequest, .offhook_request, .onhook_speed_base,
		.spark_quench_sel, .tip_ring_volt_adj, .line_volt_raw, .ac_impedance_select,
		.termination_global, .fullscale_mode, .rx_highpass_sel, .dct_ref_mv,
		.line_volt_reading, .tip_ring_polarity, .offhook_valid, .loop_current_on);
	line_side_model line_side_model_i (.connected, .volts, .line_volt_raw);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic close_out();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			close_out();
		end
	end

	task automatic check(string what, logic [31:0] got, logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, got);
		end
	endtask : check

	// Holds the request until waitrequest is seen low at an edge
	task automatic bus(logic wr, logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		address <= a;
		write <= wr;
		read <= !wr;
		writedata <= {24'h0, d};
		do @(posedge clk); while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(negedge clk);
	endtask : bus

	task automatic rdc(string what, logic [7:0] a, logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		check(what, rd, {24'h0, exp});
	endtask : rdc

	task automatic span(logic rel);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((rel ? loop_current_on !== 1'b0 : offhook_valid !== 1'b1) && n < 1100);
	endtask : span

	// Pipeline slack of a few cycles around the count
	task automatic near(string what, int exp);
		check(what, 32'(n >= exp - 1 && n <= exp + 4), 32'h1);
	endtask : near

	task automatic t_reset();
		rdc("term", 8'h78, 8'h00);
		rdc("ctl5", 8'h7C, 8'h20);
		check("scale", fullscale_mode, FS_DEFAULT);
		check("corner", rx_highpass_sel, HP_5HZ);
		check("idle wait", waitrequest, 32'h0);
		$display("done reset");
	endtask : t_reset

	task automatic t_imp();
		for (int i = 0; i < 16; i++) begin
			bus(1'b1, 8'h78, 8'hE0 | 8'(i));
			rdc("imp rd", 8'h78, 8'h20 | 8'(i));
			check("imp", ac_impedance_select, 32'(i));
			check("global", termination_global, 32'(i == 15));
		end
		bus(1'b1, 8'h78, 8'h01);
		rdc("spare", 8'h78, 8'h01);
		bus(1'b1, 8'h78, 8'h02);
		check("reduced", ac_impedance_select, 32'h2);
		$display("done impedance");
	endtask : t_imp

	task automatic t_scale();
		@(posedge clk);
		tip_ring_volt_adj <= 2'h3;
		bus(1'b1, 8'h78, 8'h10);
		check("boost", fullscale_mode, FS_BOOST_6);
		bus(1'b1, 8'h7C, 8'hFF);
		rdc("ctl5 rd", 8'h7C, 8'hEB);
		check("both", fullscale_mode, FS_BOOST_6);
		check("corner", rx_highpass_sel, HP_200HZ);
		bus(1'b1, 8'h78, 8'h00);
		check("std", fullscale_mode, FS_STD_3P2);
		bus(1'b1, 8'h7C, 8'h80);
		check("std wr", fullscale_mode, FS_STD_3P2);
		bus(1'b1, 8'h7C, 8'h20);
		check("dflt", fullscale_mode, FS_DEFAULT);
		check("corner", rx_highpass_sel, HP_5HZ);
		$display("done scale");
	endtask : t_scale

	// Speed bits are base, ext, quench pair
	task automatic t_hook();
		logic [3:0] md[4] = '{4'h0, 4'h4, 4'hB, 4'h0};
		// Hook times in us, times 100 cycles per us, over the divider of 50000
		int fo[4] = '{1024, 256, 128, 16};
		int on[4] = '{1, 6, 52, 1};
		for (int c = 0; c < 4; c++) begin
			@(posedge clk);
			onhook_speed_base <= md[c][3];
			spark_quench_sel <= md[c][1:0];
			bus(1'b1, 8'h7C, {1'b0, 2'(c), 1'b0, md[c][2], 3'h0});
			@(posedge clk);
			offhook_request <= 1'b1;
			span(1'b0);
			near("offhook", fo[c]);
			offhook_request <= 1'b0;
			span(1'b1);
			near("onhook", on[c]);
		end
		$display("done hook");
	endtask : t_hook

	task automatic t_volt();
		logic [8:0] tab[6] = '{9'h003, 9'h0FD, 9'h004, 9'h0FC, 9'h080, 9'h102};
		logic [7:0] ex[6] = '{8'h00, 8'h00, 8'h04, 8'hFC, 8'h80, 8'h02};
		logic [11:0] mv[4] = '{12'hC1C, 12'hC80, 12'hD16, 12'hDAC};
		for (int k = 0; k < 6; k++) begin
			bus(1'b1, 8'h7C, {7'h10, tab[k][8]});
			@(posedge clk);
			volts <= tab[k][7:0];
			rdc("volt", 8'h74, ex[k]);
			check("volt port", line_volt_reading, ex[k]);
			check("polarity", tip_ring_polarity, ex[k][7]);
		end
		bus(1'b1, 8'h74, 8'h55);
		rdc("ro", 8'h74, 8'h02);
		rdc("unmapped", 8'h40, 8'h00);
		rdc("misalign", 8'h7D, 8'h00);
		@(posedge clk);
		connected <= 1'b0;
		rdc("no line", 8'h74, 8'h00);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			tip_ring_volt_adj <= 2'(i);
			@(negedge clk);
			check("dct", dct_ref_mv, mv[i]);
		end
		$display("done volt");
	endtask : t_volt

	initial begin
		rst_n = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 8'h00;
		writedata = 32'h0;
		offhook_request = 1'b0;
		onhook_speed_base = 1'b0;
		spark_quench_sel = 2'h0;
		tip_ring_volt_adj = 2'h0;
		connected = 1'b1;
		volts = 8'h00;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_imp();
		t_scale();
		t_hook();
		t_volt();
		close_out();
	end
endmodule : testbench
